//--- core/dsp_link_if.sv
// link between the burst memory controller and the burst sram device
// the shared data pins are resolved here from the two output enables
`timescale 1ns/1ps
`default_nettype none

interface dsp_link_if;
    import dsp_pkg::*;

    logic k;
    logic k_n;
    logic ld_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic latency_mode_select;
    logic [WORD_W-1:0] dq_h;
    logic dq_h_oe;
    logic [WORD_W-1:0] dq_d;
    logic dq_d_oe;
    logic [WORD_W-1:0] dq;
    logic returned_timing_output;
    logic returned_timing_output_n;
    logic read_valid_flag;

    // wire level: whoever enables drives, the controller if both do, otherwise the pins read as zero
    assign dq = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : '0);

    modport dev (
        input k,
        input k_n,
        input ld_n,
        input rw,
        input addr,
        input latency_mode_select,
        input dq,
        output dq_d,
        output dq_d_oe,
        output returned_timing_output,
        output returned_timing_output_n,
        output read_valid_flag
    );

    modport host (
        output k,
        output k_n,
        output ld_n,
        output rw,
        output addr,
        output latency_mode_select,
        output dq_h,
        output dq_h_oe,
        input dq,
        input returned_timing_output,
        input returned_timing_output_n,
        input read_valid_flag
    );

endinterface

`default_nettype wire

//--- core/dsp_mem_ctrl.sv
// controller end: makes the link clocks, issues two-word bursts, gathers reads
// assumes a user that holds REQ_VALID and data until REQ_READY takes them
`timescale 1ns/1ps
`default_nettype none

module dsp_mem_ctrl (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    dsp_link_if.host LINK,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [dsp_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [dsp_pkg::BURST_W-1:0] REQ_WDATA,
    input wire logic LATENCY_MODE,
    output logic RD_VALID,
    output logic [dsp_pkg::BURST_W-1:0] RD_DATA
);
    import dsp_pkg::*;

    dsp_ct_t c_ff;
    dsp_ct_t nxt_c;
    logic take;
    logic s_vld;
    logic s_cq;
    logic [WORD_W-1:0] s_dq;

    // one issue slot per link cycle, closed while a spacing gap runs
    assign REQ_READY = (c_ff.ph == PH_ISSUE) && (c_ff.gap == 2'h0);
    assign take = REQ_VALID && REQ_READY;
    assign {s_vld, s_cq, s_dq} = c_ff.s2;

    always_comb
    begin
        nxt_c = c_ff;
        nxt_c.rd_valid = 1'b0;
        // link clock divider; ph 0..3 true clock high
        nxt_c.ph = c_ff.ph + 3'h1;
        nxt_c.k = nxt_c.ph < PH_HALF;
        nxt_c.k_n = !(nxt_c.ph < PH_HALF);
        nxt_c.lat = LATENCY_MODE;
        // pins from the device pass two flops before anything looks
        nxt_c.s1 = {LINK.read_valid_flag, LINK.returned_timing_output, LINK.dq};
        nxt_c.s2 = c_ff.s1;

        // address and second write beat change two phases before a true rise
        if (c_ff.ph == PH_ISSUE)
        begin
            nxt_c.ld_n = LOAD_IDLE_N;
            if (c_ff.wstep == WS_BEAT1)
            begin
                nxt_c.dq_o = word_sel(c_ff.wdata, 1'b1);
                nxt_c.wstep = WS_RELEASE;
            end
            if (take)
            begin
                nxt_c.ld_n = 1'b0;
                nxt_c.rw = !REQ_WRITE;
                nxt_c.addr = REQ_ADDR;
                nxt_c.wdata = REQ_WDATA;
                nxt_c.wstep = REQ_WRITE ? WS_BEAT0 : WS_IDLE;
                // after a read the pins stay with the device for up to
                // 3.5 cycles, so a following write waits longer
                nxt_c.gap = REQ_WRITE ? GAP_AFTER_WR : GAP_AFTER_RD;
            end
            else if (c_ff.gap != 2'h0)
            begin
                nxt_c.gap = c_ff.gap - 2'h1;
            end
        end

        // first write beat for the complementary rise; release one cycle on
        if (c_ff.ph == PH_BEAT0)
        begin
            if (c_ff.wstep == WS_BEAT0)
            begin
                nxt_c.dq_o = word_sel(c_ff.wdata, 1'b0);
                nxt_c.dq_oe = 1'b1;
                nxt_c.wstep = WS_BEAT1;
            end
            else if (c_ff.wstep == WS_RELEASE)
            begin
                nxt_c.dq_oe = 1'b0;
                nxt_c.wstep = WS_IDLE;
            end
        end

        // capture mid-half, framed by the valid flag and checked against
        // the echo clock level, so either latency needs no set-up here
        if (s_vld && (((c_ff.ph == PH_CAP_HI_HALF) && s_cq) || ((c_ff.ph == PH_CAP_LO_HALF) && !s_cq)))
        begin
            if (!c_ff.beat)
            begin
                nxt_c.lo = s_dq;
                nxt_c.beat = 1'b1;
            end
            else
            begin
                nxt_c.rd_data = {s_dq, c_ff.lo};
                nxt_c.rd_valid = 1'b1;
                nxt_c.beat = 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            c_ff <= '0;
            c_ff.ld_n <= LOAD_IDLE_N;
            c_ff.rw <= RW_READ;
        end
        else
        begin
            c_ff <= nxt_c;
        end
    end

    assign LINK.k = c_ff.k;
    assign LINK.k_n = c_ff.k_n;
    assign LINK.ld_n = c_ff.ld_n;
    assign LINK.rw = c_ff.rw;
    assign LINK.addr = c_ff.addr;
    assign LINK.latency_mode_select = c_ff.lat;
    assign LINK.dq_h = c_ff.dq_o;
    assign LINK.dq_h_oe = c_ff.dq_oe;
    assign RD_VALID = c_ff.rd_valid;
    assign RD_DATA = c_ff.rd_data;

endmodule

`default_nettype wire

//--- core/dsp_pkg.sv
// constants and state types shared by both ends of the two-word burst port
// assumes the 18-bit organisation: 2M burst addresses of two 18-bit words
package dsp_pkg;

    // port geometry
    localparam int WORD_W = 18;
    localparam int BURST_W = 2 * WORD_W;
    localparam int ADDR_W = 21;
    localparam int SYNC_W = WORD_W + 2;

    // link clock made by the controller: core clock divided by LINK_DIV
    localparam int PH_W = 3;
    localparam int LINK_DIV = 8;
    localparam logic [PH_W-1:0] PH_HALF = 3'h4;
    localparam logic [PH_W-1:0] PH_ISSUE = 3'h5;
    localparam logic [PH_W-1:0] PH_BEAT0 = 3'h1;
    localparam logic [PH_W-1:0] PH_CAP_HI_HALF = 3'h4;
    localparam logic [PH_W-1:0] PH_CAP_LO_HALF = 3'h0;

    // link cycles a new address must wait after a read or a write
    localparam logic [1:0] GAP_AFTER_RD = 2'h3;
    localparam logic [1:0] GAP_AFTER_WR = 2'h1;

    // write beat sequencer steps
    localparam logic [1:0] WS_IDLE = 2'h0;
    localparam logic [1:0] WS_BEAT0 = 2'h1;
    localparam logic [1:0] WS_BEAT1 = 2'h2;
    localparam logic [1:0] WS_RELEASE = 2'h3;

    // reset values
    localparam logic LOAD_IDLE_N = 1'b1;
    localparam logic RW_READ = 1'b1;

    // device state on the rising edge of the true link clock
    typedef struct packed {
        logic lat;
        logic busy;
        logic rd_pend;
        logic wr_pend;
        logic rd_d1;
        logic rd_d2;
        logic wcommit;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] waddr;
        logic [WORD_W-1:0] wb0c;
        logic [WORD_W-1:0] wb1;
        logic [BURST_W-1:0] word;
        logic [WORD_W-1:0] q;
        logic v;
    } dsp_kst_t;

    // device state on the rising edge of the complementary link clock
    typedef struct packed {
        logic [WORD_W-1:0] wb0;
        logic [WORD_W-1:0] q;
        logic v;
    } dsp_knst_t;

    // controller state, all on the core clock
    typedef struct packed {
        logic [PH_W-1:0] ph;
        logic k;
        logic k_n;
        logic ld_n;
        logic rw;
        logic lat;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] dq_o;
        logic dq_oe;
        logic [BURST_W-1:0] wdata;
        logic [1:0] wstep;
        logic [1:0] gap;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [WORD_W-1:0] lo;
        logic beat;
        logic rd_valid;
        logic [BURST_W-1:0] rd_data;
    } dsp_ct_t;

    // pick word 0 (low) or word 1 (high) of a burst
    function automatic logic [WORD_W-1:0] word_sel(input logic [BURST_W-1:0] w, input logic hi);
        word_sel = hi ? w[BURST_W-1:WORD_W] : w[WORD_W-1:0];
    endfunction

endpackage

//--- core/dsp_sram_dev.sv
// burst sram device end: two-word burst array behind a double-data-rate port
// assumes the controller makes both link clocks and keeps the load spacing
`timescale 1ns/1ps
`default_nettype none

module dsp_sram_dev (
    dsp_link_if.dev LINK,
    input wire logic LINK_RST
);
    import dsp_pkg::*;

    // burst array: one entry holds both words of an address
    logic [BURST_W-1:0] mem [0:(2**ADDR_W)-1];

    dsp_kst_t k_ff;
    dsp_kst_t nxt_k;
    dsp_knst_t kn_ff;
    dsp_knst_t nxt_kn;
    logic accept;
    logic [BURST_W-1:0] rd_now;

    // array read port, used by the short-latency launch and the word holder
    assign rd_now = mem[k_ff.addr];

    // true-clock side: address capture, read pipeline, write assembly
    always_comb
    begin
        nxt_k = k_ff;
        // a load right after an accepted one is ignored, so the
        // second edge of every burst can never start a new one
        accept = !LINK.ld_n && !k_ff.busy;
        nxt_k.busy = accept;
        nxt_k.lat = LINK.latency_mode_select;
        nxt_k.rd_pend = accept && LINK.rw;
        nxt_k.wr_pend = accept && !LINK.rw;
        if (accept)
        begin
            nxt_k.addr = LINK.addr;
        end

        // read pipeline: word fetched one edge after the address
        nxt_k.rd_d1 = k_ff.rd_pend;
        nxt_k.rd_d2 = k_ff.rd_d1;
        if (k_ff.rd_pend)
        begin
            nxt_k.word = rd_now;
        end

        // second write beat lands on the true edge after the address;
        // the first beat is copied over from the complementary side
        nxt_k.wcommit = k_ff.wr_pend;
        if (k_ff.wr_pend)
        begin
            nxt_k.waddr = k_ff.addr;
            nxt_k.wb1 = LINK.dq;
            nxt_k.wb0c = kn_ff.wb0;
        end

        // true-edge launch: word 0 in short mode, word 1 in long mode
        nxt_k.v = 1'b0;
        if (!k_ff.lat && k_ff.rd_pend)
        begin
            nxt_k.v = 1'b1;
            nxt_k.q = word_sel(rd_now, 1'b0);
        end
        else if (k_ff.lat && k_ff.rd_d2)
        begin
            nxt_k.v = 1'b1;
            nxt_k.q = word_sel(k_ff.word, 1'b1);
        end
    end

    // complementary-clock side: first write beat and the other read beat
    always_comb
    begin
        nxt_kn = kn_ff;
        nxt_kn.v = 1'b0;
        if (k_ff.wr_pend)
        begin
            nxt_kn.wb0 = LINK.dq;
        end
        if (!k_ff.lat && k_ff.rd_d1)
        begin
            nxt_kn.v = 1'b1;
            nxt_kn.q = word_sel(k_ff.word, 1'b1);
        end
        else if (k_ff.lat && k_ff.rd_d2)
        begin
            // half a cycle before the true edge that sends word 1
            nxt_kn.v = 1'b1;
            nxt_kn.q = word_sel(k_ff.word, 1'b0);
        end
    end

    // true-clock registers; rising edge only
    always_ff @(posedge LINK.k or posedge LINK_RST)
    begin
        if (LINK_RST)
        begin
            k_ff <= '0;
        end
        else
        begin
            k_ff <= nxt_k;
        end
    end

    // complementary-clock registers; its rising edge stands in for
    // the falling edge of the true clock, which is never used
    always_ff @(posedge LINK.k_n or posedge LINK_RST)
    begin
        if (LINK_RST)
        begin
            kn_ff <= '0;
        end
        else
        begin
            kn_ff <= nxt_kn;
        end
    end

    // self-timed array write: a full cycle after the second beat, so a
    // read of the same address issued next can already see the new data
    always_ff @(posedge LINK.k)
    begin
        if (k_ff.wcommit)
        begin
            mem[k_ff.waddr] <= {k_ff.wb1, k_ff.wb0c};
        end
    end

    // output cells: the clock level picks which launch register is on
    // the pins, as a double-data-rate output stage would; both halves
    // are plain flop outputs so no logic glitch reaches the data
    assign LINK.dq_d = LINK.k ? k_ff.q : kn_ff.q;
    assign LINK.dq_d_oe = LINK.k ? k_ff.v : kn_ff.v;
    assign LINK.read_valid_flag = LINK.k ? k_ff.v : kn_ff.v;

    // echo clocks run with the input clocks that launch the data; in
    // silicon they get the output-path delay, here they are zero-delay
    assign LINK.returned_timing_output = LINK.k;
    assign LINK.returned_timing_output_n = LINK.k_n;

endmodule

`default_nettype wire

//--- verif/dsp_link_sva.sv
// checker on the link between the burst controller and the burst sram device
// assumes link flops move on CORE_CLK edges; both resets active high
`timescale 1ns/1ps
`default_nettype none

module dsp_link_sva (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic LINK_RST,
    input wire logic k,
    input wire logic k_n,
    input wire logic ld_n,
    input wire logic rw,
    input wire logic [dsp_pkg::ADDR_W-1:0] addr,
    input wire logic latency_mode_select,
    input wire logic dq_h_oe,
    input wire logic dq_d_oe,
    input wire logic returned_timing_output,
    input wire logic returned_timing_output_n,
    input wire logic read_valid_flag
);
    import dsp_pkg::*;

    // device data, drive and flag outputs read 0 in its reset, so both resets mask the checks
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST || LINK_RST);

    k_comp_a: assert property (k |-> !k_n)
        else $error("both link clocks high");
    echo_align_a: assert property (returned_timing_output == k && returned_timing_output_n == k_n)
        else $error("echo clocks off the link clocks");
    valid_flag_a: assert property (read_valid_flag == dq_d_oe)
        else $error("read valid flag differs from device drive");
    // two beats of half a link cycle each: the flag stands one link cycle
    burst_span_a: assert property ($rose(read_valid_flag) |-> read_valid_flag [*8] ##1 !read_valid_flag)
        else $error("read valid flag not one link cycle long");
    pin_clash_a: assert property (!(dq_h_oe && dq_d_oe))
        else $error("both ends drive the data pins");
    load_gap_a: assert property ($rose(ld_n) |-> ld_n [*8])
        else $error("loads closer than two link cycles");
    addr_hold_a: assert property ((!ld_n && !$past(ld_n)) |-> $stable(addr) && $stable(rw))
        else $error("address or direction moved during a load");
    wr_burst_a: assert property ($rose(dq_h_oe) |-> dq_h_oe [*8] ##1 !dq_h_oe)
        else $error("write burst not one link cycle long");
    // one link cycle is 8 core cycles; the load is seen in the same core cycle that k rises
    rd_lat_one_a: assert property (($rose(k) && !ld_n && rw && !latency_mode_select) |->
        ##7 !read_valid_flag ##1 read_valid_flag [*8] ##1 !read_valid_flag)
        else $error("short latency read misplaced");
    rd_lat_half_a: assert property (($rose(k) && !ld_n && rw && latency_mode_select) |->
        ##19 !read_valid_flag ##1 read_valid_flag [*8] ##1 !read_valid_flag)
        else $error("long latency read misplaced");
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench: controller and device joined by the link interface
// assumes the controller makes the link clocks from CORE_CLK
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dsp_pkg::*;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic link_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [BURST_W-1:0] req_wdata = '0;
    logic latency_mode = 1'b0;
    logic req_ready;
    logic rd_valid;
    logic [BURST_W-1:0] rd_data;
    logic [WORD_W-1:0] pins;
    logic rvf;
    int bad_count = 0;
    int cmp_count = 0;

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    dsp_link_if dsp_link_if_inst ();
    assign pins = dsp_link_if_inst.dq;
    assign rvf = dsp_link_if_inst.read_valid_flag;

    dsp_mem_ctrl dsp_mem_ctrl_inst (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK(dsp_link_if_inst.host),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .LATENCY_MODE(latency_mode), .RD_VALID(rd_valid), .RD_DATA(rd_data)
    );
    dsp_sram_dev dsp_sram_dev_inst (.LINK(dsp_link_if_inst.dev), .LINK_RST(link_rst));
    dsp_link_sva dsp_link_sva_inst (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK_RST(link_rst),
        .k(dsp_link_if_inst.k), .k_n(dsp_link_if_inst.k_n), .ld_n(dsp_link_if_inst.ld_n),
        .rw(dsp_link_if_inst.rw), .addr(dsp_link_if_inst.addr),
        .latency_mode_select(dsp_link_if_inst.latency_mode_select),
        .dq_h_oe(dsp_link_if_inst.dq_h_oe), .dq_d_oe(dsp_link_if_inst.dq_d_oe),
        .returned_timing_output(dsp_link_if_inst.returned_timing_output),
        .returned_timing_output_n(dsp_link_if_inst.returned_timing_output_n),
        .read_valid_flag(dsp_link_if_inst.read_valid_flag)
    );

    task automatic check(input string what, input logic [BURST_W-1:0] seen, input logic [BURST_W-1:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // a wait that ran out ends the run through the same report
    task automatic timed_out(input string what);
        bad_count++;
        $display("[FAIL] %s expected done seen timeout", what);
        give_verdict();
    endtask

    // hold the request until ready takes it; a refusal past 64 cycles ends the run
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [BURST_W-1:0] d);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        for (n = 0; n < 64 && req_ready !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 64)
            timed_out("request");
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask

    task automatic expect_read(input string what, input logic [BURST_W-1:0] exp);
        int n;
        for (n = 0; n < 80 && rd_valid !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 80)
            timed_out(what);
        check(what, rd_data, exp);
    endtask

    // outputs quiet and pins released while reset is held
    task automatic sc_reset();
        @(negedge core_clk);
        check("reset outs", {32'h0, req_ready, rd_valid, dsp_link_if_inst.dq_h_oe, dsp_link_if_inst.ld_n}, 36'h1);
        check("reset data", rd_data, 36'h0);
    endtask

    // one write and its read-back, watching each beat on the shared pins
    task automatic sc_beats(input logic mode, input logic [ADDR_W-1:0] a, input logic [BURST_W-1:0] d, output int lat);
        @(negedge core_clk);
        latency_mode = mode;
        issue(1'b1, a, d);
        @(posedge dsp_link_if_inst.k_n);
        #1 check("wr beat0", {18'h0, pins}, {18'h0, d[17:0]});
        @(posedge dsp_link_if_inst.k);
        #1 check("wr beat1", {18'h0, pins}, {18'h0, d[35:18]});
        issue(1'b0, a, '0);
        for (lat = 0; lat < 40 && rvf !== 1'b1; lat++)
            @(negedge core_clk);
        if (lat == 40)
            timed_out("read beats");
        check("rd beat0", {18'h0, pins}, {18'h0, d[17:0]});
        @(dsp_link_if_inst.k);
        #1 check("rd beat1", {18'h0, pins}, {18'h0, d[35:18]});
        expect_read("rd data", d);
    endtask

    // both ends of the address range back to back, then an overwrite read at once
    task automatic sc_bounds();
        issue(1'b1, '0, {18'h3ffff, 18'h00001});
        issue(1'b1, '1, {18'h00002, 18'h3fffe});
        issue(1'b0, '0, '0);
        expect_read("low addr", {18'h3ffff, 18'h00001});
        issue(1'b0, '1, '0);
        expect_read("top addr", {18'h00002, 18'h3fffe});
        issue(1'b1, '0, {18'h12345, 18'h0abcd});
        issue(1'b0, '0, '0);
        expect_read("overwrite", {18'h12345, 18'h0abcd});
    endtask

    // device reset spans several link periods and ends before the first load
    initial
    begin
        int lat0;
        int lat1;
        sc_reset();
        repeat (9) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (20) @(negedge core_clk);
        link_rst = 1'b0;
        sc_beats(1'b0, 21'h0000a5, {18'h2aaaa, 18'h15555}, lat0);
        sc_beats(1'b1, 21'h15a5a5, {18'h15555, 18'h2aaaa}, lat1);
        check("latency step", BURST_W'(lat1 - lat0), 36'hc);
        sc_bounds();
        give_verdict();
    end

    // overall guard in case the link stalls
    initial
    begin
        repeat (20000) @(negedge core_clk);
        timed_out("run");
    end
endmodule

`default_nettype wire
